// file: include/nfc_defines.vh
/*
 * Constants for the NAND flash host controller: command codes, address
 * layout, frame size and pin timing counts at a 40 MHz system clock.
 * Assumes it is included once per compilation unit by its bare name.
 */
`ifndef NFC_DEFINES_VH
`define NFC_DEFINES_VH

// Clock rate in MHz, used to turn nanoseconds into cycles
`define NFC_CLK_MHZ 40
// Command codes
`define NFC_CMD_READ 8'h00
`define NFC_CMD_RESET 8'hff
`define NFC_CMD_STATUS 8'h70
`define NFC_CMD_READ_ID 8'h90
`define NFC_CMD_PROG_SETUP 8'h80
`define NFC_CMD_PROG_CONFIRM 8'h10
`define NFC_CMD_ERASE_SETUP 8'h60
`define NFC_CMD_ERASE_CONFIRM 8'hd0
// Operation codes on the user port
`define NFC_OP_READ 3'h0
`define NFC_OP_PROG 3'h1
`define NFC_OP_ERASE 3'h2
`define NFC_OP_STATUS 3'h3
`define NFC_OP_RESET 3'h4
`define NFC_OP_READ_ID 3'h5
// Address layout
`define NFC_ADDR_W 19
`define NFC_FRAME_BYTES 6'h20
// Status byte fields
`define NFC_ST_READY_BIT 6
`define NFC_ST_FAIL_BIT 0
// Strobe timing: write cycle 120 ns, strobe low 60 ns, min times round up
`define NFC_T_CYCLE_NS 120
`define NFC_T_LOW_NS 60
`define NFC_T_WHR_NS 100
`define NFC_CYC_CYCLE ((`NFC_T_CYCLE_NS*`NFC_CLK_MHZ+999)/1000)
`define NFC_CYC_LOW ((`NFC_T_LOW_NS*`NFC_CLK_MHZ+999)/1000)
`define NFC_CYC_WHR ((`NFC_T_WHR_NS*`NFC_CLK_MHZ+999)/1000)
// Busy line settles within 200 ns after the last write strobe
`define NFC_T_WB_NS 200
`define NFC_CYC_WB ((`NFC_T_WB_NS*`NFC_CLK_MHZ+999)/1000)

`endif

// file: rtl/nfc_host.v
/*
 * Host controller for a small 512K x 8 NAND flash: sequences command,
 * address, data and read strobe cycles on the shared byte bus from one
 * user request, and buffers read bytes in a two-entry buffer that never holds more than one.
 * Assumes the flash pins are synchronous to clk_sys and that the board
 * resolves the shared bus from the output enable.
 */
// Contract
// - Bytes move only with select low, write strobed
// - Command latch high marks a command byte
// - Address latch high marks address, else data
// - Single-cycle codes: 00, FF, 70, 90
// - Program 80 then 10; erase 60 then D0
// - Only reset or status while busy
// - 19-bit address sent low byte first
// - Read and program take three address cycles
// - Erase takes only the two row bytes
`include "nfc_defines.vh"
`default_nettype none

module nfc_host (
    input wire clk_sys,
    input wire sys_rst,
    // User request port
    input wire req_valid,
    output reg req_ready,
    input wire [2:0] req_op,
    input wire [18:0] req_addr,
    input wire [5:0] req_len,
    // Write data stream for program
    input wire wr_valid,
    output reg wr_ready,
    input wire [7:0] wr_data,
    // Read data stream out of the buffer
    output reg rd_valid,
    input wire rd_ready,
    output reg [7:0] rd_data,
    output reg done,
    // Flash pins
    output reg chip_sel_n,
    output reg cmd_latch,
    output reg addr_latch,
    output reg write_strobe_n,
    output reg read_strobe_n,
    output reg write_prot_n,
    input wire ready_busy_n,
    input wire [7:0] shared_byte_bus_in,
    output reg [7:0] shared_byte_bus_out,
    output reg shared_byte_bus_oe
);

    // States
    localparam S_IDLE = 4'h0;
    localparam S_CMD = 4'h1;
    localparam S_ADDR = 4'h2;
    localparam S_DATA = 4'h3;
    localparam S_CONF = 4'h4;
    localparam S_WAIT = 4'h5;
    localparam S_RD = 4'h6;
    localparam S_FIN = 4'h7;

    reg [3:0] state;
    reg [2:0] op; // Latched operation
    reg [18:0] addr; // Latched address
    reg [5:0] left; // Bytes still to move
    reg [1:0] acnt; // Address bytes remaining
    reg [3:0] tcnt; // Strobe phase timer
    reg [7:0] wbyte; // Byte being written
    // Two-entry read buffer
    reg [7:0] buf0, buf1;
    reg [1:0] fill;
    wire buf_room = (fill != 2'h2);
    wire push;
    wire pop = rd_valid & rd_ready;

    // Phase timer ends: strobe released at LOW, cycle over at CYCLE - 1
    wire t_low = (tcnt == `NFC_CYC_LOW);
    wire t_end = (tcnt == `NFC_CYC_CYCLE - 1);

    // Read byte taken at strobe release, only when buffer has room
    assign push = (state == S_RD) & t_low & ~read_strobe_n;

    // Buffer: shift register of two words, stall by withholding strobe
    always @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            fill <= 2'h0;
            rd_valid <= 1'b0;
            buf0 <= 8'h00;
            buf1 <= 8'h00;
        end else begin
            if (push & ~pop) begin
                if (fill == 2'h0) buf0 <= shared_byte_bus_in;
                else buf1 <= shared_byte_bus_in;
                fill <= fill + 2'h1;
                rd_valid <= 1'b1;
            end else if (pop & ~push) begin
                buf0 <= buf1;
                fill <= fill - 2'h1;
                // Still valid while the second word remains
                rd_valid <= (fill == 2'h2);
            end else if (pop & push) begin
                if (fill == 2'h1) buf0 <= shared_byte_bus_in;
                else begin
                    buf0 <= buf1;
                    buf1 <= shared_byte_bus_in;
                end
            end
        end
    end

    // Combinational view of the buffer head
    always @* begin
        rd_data = buf0;
    end

    // Main sequencer
    always @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            state <= S_IDLE;
            op <= 3'h0;
            addr <= 19'h00000;
            left <= 6'h00;
            acnt <= 2'h0;
            tcnt <= 4'h0;
            wbyte <= 8'h00;
            req_ready <= 1'b0;
            wr_ready <= 1'b0;
            done <= 1'b0;
            chip_sel_n <= 1'b1;
            cmd_latch <= 1'b0;
            addr_latch <= 1'b0;
            write_strobe_n <= 1'b1;
            read_strobe_n <= 1'b1;
            write_prot_n <= 1'b0; // Protect until a write is requested
            shared_byte_bus_out <= 8'h00;
            shared_byte_bus_oe <= 1'b0;
        end else begin
            done <= 1'b0;
            wr_ready <= 1'b0;
            case (state)
            S_IDLE: begin
                // Select dropped between operations, ends any read
                chip_sel_n <= 1'b1;
                shared_byte_bus_oe <= 1'b0;
                cmd_latch <= 1'b0;
                addr_latch <= 1'b0;
                req_ready <= ready_busy_n;
                if (req_valid & req_ready) begin
                    req_ready <= 1'b0;
                    op <= req_op;
                    addr <= req_addr;
                    // Clip to frame end, device stops at last column
                    if (req_len == 6'h00 ||
                        {1'b0, req_len} + {2'h0, req_addr[4:0]} >
                        {1'b0, `NFC_FRAME_BYTES})
                        left <= `NFC_FRAME_BYTES - {1'b0, req_addr[4:0]};
                    else
                        left <= req_len;
                    // Protect lifted only for program and erase
                    write_prot_n <= (req_op == `NFC_OP_PROG) |
                                    (req_op == `NFC_OP_ERASE);
                    case (req_op)
                    `NFC_OP_READ: wbyte <= `NFC_CMD_READ;
                    `NFC_OP_PROG: wbyte <= `NFC_CMD_PROG_SETUP;
                    `NFC_OP_ERASE: wbyte <= `NFC_CMD_ERASE_SETUP;
                    `NFC_OP_STATUS: wbyte <= `NFC_CMD_STATUS;
                    `NFC_OP_READ_ID: wbyte <= `NFC_CMD_READ_ID;
                    default: wbyte <= `NFC_CMD_RESET;
                    endcase
                    tcnt <= 4'h0;
                    state <= S_CMD;
                end
            end
            S_CMD, S_ADDR, S_DATA, S_CONF: begin
                // One write strobe cycle: low, then high, latch on rise
                chip_sel_n <= 1'b0;
                cmd_latch <= (state == S_CMD) | (state == S_CONF);
                addr_latch <= (state == S_ADDR);
                shared_byte_bus_oe <= 1'b1;
                shared_byte_bus_out <= wbyte;
                tcnt <= tcnt + 4'h1;
                write_strobe_n <= ~((tcnt != 4'h0) && (tcnt < `NFC_CYC_LOW));
                if (t_end) begin
                    tcnt <= 4'h0;
                    if (state == S_CMD) begin
                        if (op == `NFC_OP_READ || op == `NFC_OP_PROG) begin
                            acnt <= 2'h2;
                            wbyte <= addr[7:0];
                            state <= S_ADDR;
                        end else if (op == `NFC_OP_ERASE) begin
                            acnt <= 2'h1;
                            wbyte <= addr[15:8];
                            state <= S_ADDR;
                        end else begin
                            state <= S_WAIT;
                        end
                    end else if (state == S_ADDR) begin
                        if (acnt != 2'h0) begin
                            acnt <= acnt - 2'h1;
                            // Next byte; top bits don't care, sent as zero
                            wbyte <= (acnt == 2'h2) ? addr[15:8] :
                                     {5'h00, addr[18:16]};
                        end else if (op == `NFC_OP_PROG) begin
                            wr_ready <= 1'b1;
                            state <= S_DATA;
                            tcnt <= 4'h0;
                        end else if (op == `NFC_OP_ERASE) begin
                            wbyte <= `NFC_CMD_ERASE_CONFIRM;
                            state <= S_CONF;
                        end else begin
                            state <= S_WAIT;
                        end
                    end else if (state == S_DATA) begin
                        left <= left - 6'h01;
                        if (left == 6'h01) begin
                            wbyte <= `NFC_CMD_PROG_CONFIRM;
                            state <= S_CONF;
                        end else begin
                            wr_ready <= 1'b1;
                        end
                    end else begin
                        state <= S_WAIT;
                    end
                end
                // Data phase idles until a byte is accepted
                if (state == S_DATA && tcnt == 4'h0) begin
                    write_strobe_n <= 1'b1;
                    if (wr_valid & wr_ready) begin
                        wbyte <= wr_data;
                        shared_byte_bus_out <= wr_data;
                        tcnt <= 4'h1;
                    end else begin
                        wr_ready <= 1'b1;
                        tcnt <= 4'h0;
                    end
                end
            end
            S_WAIT: begin
                // Hold select low; busy line settles, then wait ready
                write_strobe_n <= 1'b1;
                cmd_latch <= 1'b0;
                addr_latch <= 1'b0;
                shared_byte_bus_oe <= 1'b0;
                if (tcnt < `NFC_CYC_WB + `NFC_CYC_WHR)
                    tcnt <= tcnt + 4'h1;
                else if (ready_busy_n) begin
                    tcnt <= 4'h0;
                    if (op == `NFC_OP_READ || op == `NFC_OP_READ_ID ||
                        op == `NFC_OP_STATUS) begin
                        if (op != `NFC_OP_READ) left <= 6'h01;
                        state <= S_RD;
                    end else begin
                        state <= S_FIN;
                    end
                end
            end
            S_RD: begin
                // Read strobe cycle, held off until the buffer is empty
                if (tcnt == 4'h0) begin
                    if (buf_room && fill == 2'h0) begin
                        read_strobe_n <= 1'b0;
                        tcnt <= 4'h1;
                    end
                end else begin
                    tcnt <= tcnt + 4'h1;
                    if (t_low) read_strobe_n <= 1'b1;
                    if (t_end) begin
                        tcnt <= 4'h0;
                        left <= left - 6'h01;
                        if (left == 6'h01) state <= S_FIN;
                    end
                end
            end
            S_FIN: begin
                // Release select; program or erase ran internally
                chip_sel_n <= 1'b1;
                write_prot_n <= 1'b0;
                done <= 1'b1;
                state <= S_IDLE;
            end
            default: state <= S_IDLE;
            endcase
        end
    end

endmodule // nfc_host

`default_nettype wire

// file: testbench/nfc_host_asserts.sv
/* Checker for the flash host pins, including the busy line.
   Assumes one clk_sys domain and a bind onto nfc_host. */
`default_nettype none
module nfc_host_asserts (
    input wire logic clk_sys,
    input wire logic sys_rst,
    input wire logic chip_sel_n,
    input wire logic cmd_latch,
    input wire logic addr_latch,
    input wire logic write_strobe_n,
    input wire logic read_strobe_n,
    input wire logic write_prot_n,
    input wire logic ready_busy_n,
    input wire logic [7:0] shared_byte_bus_out,
    input wire logic shared_byte_bus_oe
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge clk_sys); endclocking
    default disable iff (sys_rst);
    wire logic [7:0] b = shared_byte_bus_out; // Short alias
    logic [1:0] acnt; // Address strokes since the last command
    // Data strokes leave the count alone, so confirm sees the total
    always @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) acnt <= 2'h0;
        else if ($fell(write_strobe_n))
            acnt <= cmd_latch ? 2'h0 : acnt + {1'b0, addr_latch};
    end
    property p_wr_sel;
        !write_strobe_n |-> !chip_sel_n && shared_byte_bus_oe;
    endproperty
    a_wr_sel: assert property (p_wr_sel)
        else $error("stroke unselected");
    property p_wr_width;
        $fell(write_strobe_n) |=> !write_strobe_n ##1 write_strobe_n;
    endproperty
    a_wr_width: assert property (p_wr_width)
        else $error("stroke width");
    property p_cmd_code;
        $fell(write_strobe_n) && cmd_latch |-> b inside
            {8'h00, 8'hff, 8'h70, 8'h90, 8'h80, 8'h10, 8'h60, 8'hd0};
    endproperty
    a_cmd_code: assert property (p_cmd_code)
        else $error("bad code");
    property p_busy_cmd;
        $fell(write_strobe_n) && cmd_latch && !ready_busy_n
            |-> b inside {8'hff, 8'h70};
    endproperty
    a_busy_cmd: assert property (p_busy_cmd)
        else $error("busy code");
    property p_prot;
        $fell(write_strobe_n) && cmd_latch && b inside {8'h10, 8'hd0}
            |-> write_prot_n;
    endproperty
    a_prot: assert property (p_prot)
        else $error("protect low");
    property p_prog_addr;
        $fell(write_strobe_n) && cmd_latch && b == 8'h10 |-> acnt == 2'h3;
    endproperty
    a_prog_addr: assert property (p_prog_addr)
        else $error("prog addr");
    property p_erase_addr;
        $fell(write_strobe_n) && cmd_latch && b == 8'hd0 |-> acnt == 2'h2;
    endproperty
    a_erase_addr: assert property (p_erase_addr)
        else $error("erase addr");
    property p_rd_ready;
        $fell(read_strobe_n) |->
            ready_busy_n && !chip_sel_n && !shared_byte_bus_oe;
    endproperty
    a_rd_ready: assert property (p_rd_ready)
        else $error("read early");
    c_erase: cover property ($fell(write_strobe_n) && b == 8'hd0);
    c_prog: cover property ($fell(write_strobe_n) && b == 8'h10);
    c_read: cover property ($fell(read_strobe_n));
endmodule // nfc_host_asserts
bind nfc_host nfc_host_asserts u_chk (.*);
`default_nettype wire

// file: testbench/nfc_flash_model.sv
/* Behavioural flash: strokes, frame register, busy line, status.
   Assumes the bench resolves the bus and pulls the busy line up. */
`default_nettype none
module nfc_flash_model #(
    parameter logic [7:0] ID_BYTE = 8'h3c // Arbitrary identifier value
) (
    input wire logic chip_sel_n,
    input wire logic cmd_latch,
    input wire logic addr_latch,
    input wire logic write_strobe_n,
    input wire logic read_strobe_n,
    input wire logic write_prot_n,
    input wire logic [7:0] shared_byte_bus_in,
    output logic [7:0] dq,
    output logic busy
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] mem [int]; // Sparse array, absent bytes read erased
    logic [7:0] pg [32]; // Frame register
    logic [31:0] pgv = 32'h0; // Frame bytes loaded since setup
    logic [23:0] adr = 24'h0; // Address bytes, low byte first
    logic [7:0] cmd = 8'h00, q = 8'h00, b; // Mode, last output, bus
    logic [4:0] col = 5'h0; // Column counter
    logic drv = 1'b0, fail = 1'b0, fail_next = 1'b0;
    int acnt = 0, kind = 0, t_read = 200, t_prog = 2000;
    event go;
    assign b = shared_byte_bus_in;
    // Released bus shows the inverse of its last byte, never a hold
    assign dq = (drv && !chip_sel_n) ? q : ~q;
    initial busy = 1'b0;
    // Rising write stroke takes a command, address or data byte
    always @(posedge write_strobe_n) if (!chip_sel_n) begin
        if (cmd_latch &&
            (!busy || b == 8'hff || b == 8'h70)) begin
            kind = b == 8'h10 && cmd == 8'h80 && pgv != 0 ? 1 :
                b == 8'hd0 && cmd == 8'h60 ? 2 : 9;
            if (kind < 9 && write_prot_n) -> go;
            if (kind == 9) begin
                cmd = b == 8'hff ? 8'h00 : b;
                acnt = b == 8'h60;
                pgv = 32'h0;
            end
        end else if (addr_latch && !busy) begin
            adr[8 * acnt +: 8] = b;
            col = adr[4:0];
            acnt++;
            if (cmd == 8'h00 && acnt == 3) begin
                kind = 0;
                -> go;
            end
        end else if (!cmd_latch && !busy && cmd == 8'h80) begin
            pg[col] = b;
            pgv[col] = 1'b1;
            col++;
        end
    end
    // Internal program, erase or frame fetch runs without the host
    always @(go) begin : run
        int k, i;
        logic [18:0] a;
        k = kind;
        busy = 1'b1;
        #(k == 0 ? t_read : k == 1 ? t_prog : 3 * t_prog);
        for (i = 0; i < 4096; i++) begin
            a = k == 2 ? {adr[18:12], i[11:0]} : {adr[18:5], i[4:0]};
            if (k == 2 && mem.exists(a)) mem.delete(a);
            if (k == 1 && i < 32 && pgv[i]) mem[a] = pg[i];
            if (k == 0 && i < 32) pg[i] = mem.exists(a) ? mem[a] : 8'hff;
        end
        fail = k == 1 && fail_next;
        fail_next = k == 1 ? 1'b0 : fail_next;
        busy = 1'b0;
    end
    // Falling read stroke drives a byte; read mode also steps the column
    always @(negedge read_strobe_n) if (!chip_sel_n) begin
        q = cmd == 8'h70 ? {1'b0, !busy, 5'h00, fail} :
            cmd == 8'h90 ? ID_BYTE : pg[col];
        col = col + {4'h0, cmd == 8'h00};
        drv = 1'b1;
    end
    always @(posedge read_strobe_n) drv = 1'b0;
    // Select high drops a pending read, never a busy write
    always @(posedge chip_sel_n) if (!busy) acnt = 0;
endmodule // nfc_flash_model
`default_nettype wire

// file: testbench/nfc_host_bench.sv
/* Bench for the flash host with a behavioural flash model.
   Assumes nfc_defines.vh is on the include path. */
`include "nfc_defines.vh"
`default_nettype none
module nfc_host_bench;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_sys = 0, sys_rst = 1, req_valid = 0, wr_valid = 0;
    logic rd_ready = 0, req_ready, wr_ready, rd_valid, done, busy;
    logic chip_sel_n, cmd_latch, addr_latch, write_strobe_n;
    logic read_strobe_n, write_prot_n, ready_busy_n, shared_byte_bus_oe;
    logic [2:0] req_op = 3'h0;
    logic [18:0] req_addr = 19'h00000;
    logic [5:0] req_len = 6'h00;
    logic [7:0] wr_data = 8'h00, rd_data, dq, shared_byte_bus_in;
    logic [7:0] shared_byte_bus_out;
    logic [7:0] got [$]; // Bytes taken from the read stream
    int err_count = 0, cmp_count = 0, cyc = 0;
    assign shared_byte_bus_in = shared_byte_bus_oe ? shared_byte_bus_out : dq;
    assign ready_busy_n = !busy; // Pull-up on the open-drain line
    nfc_host uut (.*);
    nfc_flash_model flash (.*);
    initial begin
        forever #12.5 clk_sys = ~clk_sys;
    end
    task automatic chk(input string what, input logic [31:0] seen, exp);
        cmp_count++;
        if (seen !== exp) begin
            err_count++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic give_verdict();
        $display("Compared %0d, mismatched %0d", cmp_count, err_count);
        if (err_count == 0 && cmp_count > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    // One request with its streams; stall holds the reader off a while
    task automatic do_op(input logic [2:0] op, input logic [18:0] a,
                         input logic [5:0] n, input int stall);
        int k, wi;
        logic tk, wk, rk, rv, seen;
        logic [7:0] d;
        got = {};
        {wi, rv, seen} = 0;
        {req_op, req_addr, req_len, req_valid} = {op, a, n, 1'b1};
        wr_data = 8'hc0;
        wr_valid = op == `NFC_OP_PROG;
        for (k = 0; k < 3000 && !(seen && !rv); k++) begin
            @(posedge clk_sys);
            {tk, wk, rk, rv, d} = {req_valid & req_ready,
                wr_valid & wr_ready, rd_valid & rd_ready, rd_valid, rd_data};
            seen |= done;
            @(negedge clk_sys);
            if (tk) req_valid = 0;
            if (rk) got.push_back(d);
            wi += wk;
            if (wk) wr_data = 8'hc0 + wi[7:0];
            wr_valid = wr_valid && wi < n;
            rd_ready = k >= stall;
        end
        chk("done", seen, 1);
    endtask
    task automatic t_prog_read();
        flash.t_read = 1600; // Slow frame fetch
        do_op(`NFC_OP_PROG, 19'h5a3fc, 6'h04, 0);
        chk("prog addr", flash.adr[18:0], 19'h5a3fc);
        do_op(`NFC_OP_READ, 19'h5a3fc, 6'h04, 40);
        chk("read count", got.size(), 4);
        foreach (got[i]) chk("read byte", got[i], 8'hc0 + i);
        flash.t_read = 200;
        do_op(`NFC_OP_READ, 19'h5a3fe, 6'h00, 0);
        chk("tail count", got.size(), 2);
        chk("tail byte", got[1], 8'hc3);
        $display("prog_read done");
    endtask
    task automatic t_erase();
        do_op(`NFC_OP_ERASE, 19'h5a000, 6'h00, 0);
        chk("erase row", flash.adr[23:8], 16'h05a0);
        do_op(`NFC_OP_READ, 19'h5a3fc, 6'h04, 0);
        chk("erased count", got.size(), 4);
        foreach (got[i]) chk("erased byte", got[i], 8'hff);
        $display("erase done");
    endtask
    task automatic t_status();
        flash.fail_next = 1; // Model fails the next program
        do_op(`NFC_OP_PROG, 19'h00020, 6'h01, 0);
        do_op(`NFC_OP_STATUS, 19'h00000, 6'h00, 0);
        chk("status fail", got[0], 8'h41);
        do_op(`NFC_OP_PROG, 19'h00020, 6'h01, 0);
        do_op(`NFC_OP_STATUS, 19'h00000, 6'h00, 0);
        chk("status pass", got[0], 8'h40);
        $display("status done");
    endtask
    task automatic t_misc();
        do_op(`NFC_OP_READ_ID, 19'h00000, 6'h00, 0);
        chk("ident", got[0], 8'h3c);
        do_op(`NFC_OP_RESET, 19'h00000, 6'h00, 0);
        chk("mode", flash.cmd, 8'h00);
        $display("misc done");
    endtask
    // Cut a hang short well beyond the expected run
    always @(posedge clk_sys) begin
        cyc++;
        if (cyc == 20000) begin
            err_count++;
            give_verdict();
        end
    end
    initial begin
        repeat (8) @(negedge clk_sys);
        sys_rst = 0;
        t_prog_read();
        t_erase();
        t_status();
        t_misc();
        give_verdict();
    end
endmodule // nfc_host_bench
`default_nettype wire
